// *** hdl/xb_expansion_bus.sv ***
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// External memory expansion bus with port pin control.
// =====================================================================
// Summary of operation
// - Strobe low per external access, data around it.
// - Upper-half selects active only for 8000h-FFFFh.
// - Eighth selects active only for 2000h-3FFFh.
// - Peripheral select active only for 10C0h-10FFh.
// - Select pin as high output keeps bank off.
// - Clock output runs at quarter rate.
// - Direction line high on reads, low on writes.
// - Low wait at clock rise adds clock cycles.
// - Fetch marker low through opcode first-byte reads.
// - Address pins output only, data pins two-way.
// - Single-chip mode start makes all pins inputs.
// - Each pin selects output, input, function A, B.
// - Processor mode start puts ports on function B.
// - Processor mode sends port frame accesses outside.
// - Port frame writes still update internal registers.
// - Every bus signal individually reconfigurable as I/O.
// - Register bit n governs only pin n.
// - I/O pins use direction and data bits.
module xb_expansion_bus
    import xb_pkg::*;
(
    input wire logic mclk,                         // Oscillator clock, 250 MHz.
    input wire logic arst_n,                       // Asynchronous reset, low.
    input wire logic mode_strap,                   // High selects processor mode.
    input wire logic req_valid,                    // Core offers an access.
    output logic req_ready,                        // Request FIFO has room.
    input wire xb_req_t req,                       // Access address, data, kind.
    output logic rsp_valid,                        // Read data valid, one cycle.
    output logic [7:0] rsp_data,                   // Read data.
    output logic mode_mp,                          // Processor mode latched.
    input wire logic [XB_NPORT-1:0][7:0] pin_in,   // Pin levels.
    output logic [XB_NPORT-1:0][7:0] pin_out,      // Pin drive values.
    output logic [XB_NPORT-1:0][7:0] pin_oe        // Pin drive enables.
);

    // All state of the block.
    typedef struct packed {
        xb_port_t [XB_NPORT-1:0] port;
        logic [1:0] phase;
        xb_state_t st;
        xb_req_t cur;
        logic started;
        logic mp;
        logic stall;
        logic clk_out;
        logic strobe_n;
        logic rw;
        logic ocf_n;
        logic drive;
        logic rsp_valid;
        logic [7:0] rdata;
        logic [XB_NPORT-1:0][7:0] pin_out;
        logic [XB_NPORT-1:0][7:0] pin_oe;
    } xb_top_st_t;

    xb_top_st_t s;          // Current state.
    xb_top_st_t next_s;     // Next state.
    logic head_valid;       // FIFO holds a request.
    logic pop;              // Request taken from the FIFO.
    xb_req_t head;          // Oldest request.
    logic head_frame;       // Oldest request hits the port register frame.
    logic wait_lvl;         // Wait level, high when the pin is not in use.
    logic [1:0] fidx;       // Port addressed in the frame.

    // =================================================================
    // Request buffer
    // =================================================================
    // Stalls the core through req_ready while the FIFO is full.
    xb_fifo #(.WIDTH($bits(xb_req_t)), .DEPTH(XB_FIFO_DEPTH)) i_xb_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data(req),
        .out_valid(head_valid),
        .out_ready(pop),
        .out_data(head)
    );

    assign head_frame = (head.addr >= PORTREG_LO) && (head.addr <= PORTREG_HI);
    assign fidx = head.addr[3:2];
    // Wait is only heard while its pin carries the second function.
    assign wait_lvl = (s.port[PORT_CTRL].sel1[PD_WAIT] && s.port[PORT_CTRL].sel2[PD_WAIT])
        ? pin_in[PORT_CTRL][PD_WAIT] : 1'b1;

    // =================================================================
    // Bus engine and pin mapping
    // =================================================================
    // Runs each access over one quarter-rate clock period plus waits, starting at most every second period, then maps pins.
    always_comb
    begin
        logic fa;
        logic fb;
        logic gp;
        logic cs_up;
        logic cs_e;
        logic cs_pf;
        logic [7:0] rv;
        fa = 1'b0;
        fb = 1'b0;
        gp = 1'b0;
        cs_up = 1'b1;
        cs_e = 1'b1;
        cs_pf = 1'b1;
        rv = 8'h00;
        next_s = s;
        pop = 1'b0;
        next_s.rsp_valid = 1'b0;
        next_s.started = 1'b1;
        next_s.phase = s.phase + 2'h1;
        next_s.clk_out = next_s.phase[1];
        // Startup mode is taken once, right after reset release.
        if (!s.started)
        begin
            next_s.mp = mode_strap;
            for (int p = 0; p < XB_NPORT; p++)
            begin
                next_s.port[p].sel1 = mode_strap ? SEL_RESET_MP : SEL_RESET_MC;
                next_s.port[p].sel2 = mode_strap ? SEL_RESET_MP : SEL_RESET_MC;
                next_s.port[p].dir = 8'h00;
            end
        end
        case (s.st)
            XB_IDLE:
            begin
                if (s.started && head_valid && head_frame && !s.mp)
                begin
                    // Single-chip mode: port registers answer internally.
                    pop = 1'b1;
                    case (head.addr[1:0])
                        REG_SEL1: rv = s.port[fidx].sel1;
                        REG_SEL2: rv = s.port[fidx].sel2;
                        REG_DATA: rv = (s.port[fidx].data & s.port[fidx].dir)
                            | (pin_in[fidx] & ~s.port[fidx].dir);
                        default: rv = s.port[fidx].dir;
                    endcase
                    next_s.rsp_valid = !head.write;
                    // Read data holds until the next read; writes leave it alone.
                    next_s.rdata = head.write ? s.rdata : rv;
                end
                else if (s.started && head_valid && s.phase == PH_END)
                begin
                    // External access starts with the address phase.
                    pop = 1'b1;
                    next_s.cur = head;
                    next_s.st = XB_ACT;
                    next_s.rw = !head.write;
                    next_s.ocf_n = !(head.fetch && !head.write);
                    next_s.drive = head.write;
                    next_s.stall = 1'b0;
                end
                // Frame writes land in the port registers in either mode.
                if (pop && head_frame && head.write)
                begin
                    case (head.addr[1:0])
                        REG_SEL1: next_s.port[fidx].sel1 = head.wdata;
                        REG_SEL2: next_s.port[fidx].sel2 = head.wdata;
                        REG_DATA: next_s.port[fidx].data = head.wdata;
                        default: next_s.port[fidx].dir = head.wdata;
                    endcase
                end
            end
            XB_ACT:
            begin
                if (s.phase == PH_ADDR)
                begin
                    next_s.strobe_n = 1'b0;
                end
                else if (s.phase == PH_STROBE)
                begin
                    // Wait is sampled on the clock output's rising edge.
                    next_s.stall = !wait_lvl;
                end
                else if (s.phase == PH_END && !s.stall)
                begin
                    // Strobe rises; read data is captured on the same edge.
                    next_s.strobe_n = 1'b1;
                    next_s.rw = 1'b1;
                    next_s.ocf_n = 1'b1;
                    next_s.drive = 1'b0;
                    next_s.rsp_valid = !s.cur.write;
                    next_s.rdata = s.cur.write ? s.rdata : pin_in[PORT_DATA];
                    next_s.st = XB_IDLE;
                end
            end
            default:
            begin
                next_s.st = XB_IDLE;
            end
        endcase
        // Chip selects follow the strobe, gated by their address window.
        cs_up = next_s.strobe_n || (next_s.cur.addr < UPPER_LO)
            || (next_s.cur.addr > UPPER_HI);
        cs_e = next_s.strobe_n || (next_s.cur.addr < EIGHTH_LO)
            || (next_s.cur.addr > EIGHTH_HI);
        cs_pf = next_s.strobe_n || (next_s.cur.addr < PFRAME_LO)
            || (next_s.cur.addr > PFRAME_HI);
        // Each pin is steered by its own bit of the four registers.
        for (int p = 0; p < XB_NPORT; p++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                fa = !next_s.port[p].sel1[b] && next_s.port[p].sel2[b];
                fb = next_s.port[p].sel1[b] && next_s.port[p].sel2[b];
                gp = !next_s.port[p].sel2[b];
                next_s.pin_out[p][b] = next_s.port[p].data[b];
                next_s.pin_oe[p][b] = gp && next_s.port[p].dir[b];
                if (!gp && p == PORT_DATA)
                begin
                    next_s.pin_out[p][b] = next_s.cur.wdata[b];
                    next_s.pin_oe[p][b] = next_s.drive && (fa || fb);
                end
                else if (!gp && p != PORT_CTRL)
                begin
                    next_s.pin_out[p][b] = next_s.cur.addr[(p - PORT_LADDR) * 8 + b];
                    next_s.pin_oe[p][b] = fa || fb;
                end
                else if (fa && p == PORT_CTRL)
                begin
                    // First function: a select pin left as high output disables its bank.
                    next_s.pin_oe[p][b] = 1'b1;
                    case (b)
                        PD_EIGHTH_REGION_SELECT_2, PD_EIGHTH_REGION_SELECT_1: next_s.pin_out[p][b] = cs_e;
                        PD_UPPER_HALF_SELECT_3, PD_UPPER_HALF_SELECT_2, PD_UPPER_HALF_SELECT_1: next_s.pin_out[p][b] = cs_up;
                        PD_CLK: next_s.pin_out[p][b] = next_s.clk_out;
                        PD_RW: next_s.pin_out[p][b] = next_s.rw;
                        default: next_s.pin_out[p][b] = cs_pf;
                    endcase
                end
                else if (fb && p == PORT_CTRL)
                begin
                    // Second function: reserved bits and the wait input stay undriven.
                    next_s.pin_oe[p][b] = (b == PD_OCF) || (b == PD_CLK)
                        || (b == PD_RW) || (b == PD_EDS);
                    case (b)
                        PD_OCF: next_s.pin_out[p][b] = next_s.ocf_n;
                        PD_CLK: next_s.pin_out[p][b] = next_s.clk_out;
                        PD_RW: next_s.pin_out[p][b] = next_s.rw;
                        PD_EDS: next_s.pin_out[p][b] = next_s.strobe_n;
                        default: next_s.pin_out[p][b] = 1'b1;
                    endcase
                end
                else if (!gp)
                begin
                    next_s.pin_oe[p][b] = 1'b0;
                end
            end
        end
    end

    // Registers the state; all pins come up as undriven inputs.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '0;
            s.strobe_n <= 1'b1;
            s.rw <= 1'b1;
            s.ocf_n <= 1'b1;
            s.pin_out <= '1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign rsp_valid = s.rsp_valid;
    assign rsp_data = s.rdata;
    assign mode_mp = s.mp;
    assign pin_out = s.pin_out;
    assign pin_oe = s.pin_oe;

    // =================================================================
    // Checks
    // =================================================================
    property p_strobe_len;
        @(posedge mclk) disable iff (!arst_n)
        $fell(s.strobe_n) |-> (!s.strobe_n)[*3];
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe too short");

    property p_cs_upper;
        @(posedge mclk) disable iff (!arst_n)
        (!s.port[PORT_CTRL].sel1[PD_UPPER_HALF_SELECT_1] && s.port[PORT_CTRL].sel2[PD_UPPER_HALF_SELECT_1])
            |-> (s.pin_out[PORT_CTRL][PD_UPPER_HALF_SELECT_1] == (s.strobe_n || s.cur.addr < UPPER_LO));
    endproperty
    a_cs_upper: assert property (p_cs_upper) else $error("upper select wrong");

    property p_cs_eighth;
        @(posedge mclk) disable iff (!arst_n)
        (!s.port[PORT_CTRL].sel1[PD_EIGHTH_REGION_SELECT_1] && s.port[PORT_CTRL].sel2[PD_EIGHTH_REGION_SELECT_1])
            |-> (s.pin_out[PORT_CTRL][PD_EIGHTH_REGION_SELECT_1]
                == (s.strobe_n || s.cur.addr < EIGHTH_LO || s.cur.addr > EIGHTH_HI));
    endproperty
    a_cs_eighth: assert property (p_cs_eighth) else $error("eighth select wrong");

    property p_cs_pf;
        @(posedge mclk) disable iff (!arst_n)
        (!s.strobe_n && s.cur.addr == PFRAME_LO && !s.port[PORT_CTRL].sel1[PD_PERIPH_FRAME_SELECT]
            && s.port[PORT_CTRL].sel2[PD_PERIPH_FRAME_SELECT]) |-> !s.pin_out[PORT_CTRL][PD_PERIPH_FRAME_SELECT];
    endproperty
    a_cs_pf: assert property (p_cs_pf) else $error("frame select missing");

    property p_clk_period;
        @(posedge mclk) disable iff (!arst_n)
        $rose(s.clk_out) |-> s.clk_out ##1 s.clk_out ##1 !s.clk_out [*2] ##1 s.clk_out;
    endproperty
    a_clk_period: assert property (p_clk_period) else $error("clock not quarter rate");

    property p_rw_write;
        @(posedge mclk) disable iff (!arst_n)
        (s.st == XB_ACT && s.cur.write) |-> !s.rw;
    endproperty
    a_rw_write: assert property (p_rw_write) else $error("direction high on write");

    property p_wait_hold;
        @(posedge mclk) disable iff (!arst_n)
        (s.st == XB_ACT && s.phase == PH_STROBE && !wait_lvl) |-> ##3 !s.strobe_n;
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("wait ignored");

    property p_ocf_fetch;
        @(posedge mclk) disable iff (!arst_n)
        $fell(s.ocf_n) |-> (s.cur.fetch && !s.cur.write && s.rw);
    endproperty
    a_ocf_fetch: assert property (p_ocf_fetch) else $error("marker on non-fetch");

    property p_start_mode;
        @(posedge mclk) disable iff (!arst_n)
        $rose(s.started) |-> (s.port[PORT_DATA].sel2 == (s.mp ? SEL_RESET_MP : SEL_RESET_MC));
    endproperty
    a_start_mode: assert property (p_start_mode) else $error("startup ports wrong");

    property p_frame_ext;
        @(posedge mclk) disable iff (!arst_n)
        (pop && head_frame && s.mp) |=> (s.st == XB_ACT);
    endproperty
    a_frame_ext: assert property (p_frame_ext) else $error("frame not external");

    property p_idle_high;
        @(posedge mclk) disable iff (!arst_n)
        (s.st == XB_IDLE) |-> (s.strobe_n && s.ocf_n);
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("strobe low when idle");

endmodule
`default_nettype wire

// *** hdl/xb_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Request FIFO. DEPTH must be a power of two.
// =====================================================================
module xb_fifo
    import xb_pkg::*;
#(
    parameter int WIDTH = 26,
    parameter int DEPTH = XB_FIFO_DEPTH
)
(
    input wire logic mclk,                    // Clock.
    input wire logic arst_n,                  // Asynchronous reset, low.
    input wire logic in_valid,                // Word offered.
    output logic in_ready,                    // Room for a word.
    input wire logic [WIDTH-1:0] in_data,     // Word in.
    output logic out_valid,                   // Word waiting.
    input wire logic out_ready,               // Drain takes the word.
    output logic [WIDTH-1:0] out_data         // Oldest word.
);

    localparam int AW = $clog2(DEPTH);

    // All state of the FIFO.
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic full;
        logic empty;
    } xb_fifo_st_t;

    xb_fifo_st_t s;       // Current state.
    xb_fifo_st_t next_s;  // Next state.
    logic push;           // Word written this cycle.
    logic pop;            // Word read this cycle.

    // =================================================================
    // Next state
    // =================================================================
    // Pointers advance on push and pop; full and empty are kept as flags.
    always_comb
    begin
        next_s = s;
        push = in_valid && !s.full;
        pop = out_ready && !s.empty;
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = s.wr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd = s.rd + 1'b1;
        end
        if (push && !pop)
        begin
            next_s.count = s.count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_s.count = s.count - 1'b1;
        end
        next_s.full = (next_s.count == (AW+1)'(DEPTH));
        next_s.empty = (next_s.count == '0);
    end

    // Registers the state; the FIFO starts empty.
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s <= '{mem: '0, wr: '0, rd: '0, count: '0, full: 1'b0, empty: 1'b1};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign in_ready = !s.full;
    assign out_valid = !s.empty;
    assign out_data = s.mem[s.rd];

endmodule
`default_nettype wire

// *** hdl/xb_pkg.sv ***
`default_nettype none
// =====================================================================
// Shared constants and types of the external memory expansion bus.
// =====================================================================
package xb_pkg;

    // Port and FIFO geometry.
    localparam int XB_NPORT = 4;
    localparam int XB_PW = 8;
    localparam int XB_FIFO_DEPTH = 16;

    // Decoded address windows.
    localparam logic [15:0] UPPER_LO = 16'h8000;
    localparam logic [15:0] UPPER_HI = 16'hFFFF;
    localparam logic [15:0] EIGHTH_LO = 16'h2000;
    localparam logic [15:0] EIGHTH_HI = 16'h3FFF;
    localparam logic [15:0] PFRAME_LO = 16'h10C0;
    localparam logic [15:0] PFRAME_HI = 16'h10FF;
    localparam logic [15:0] PORTREG_LO = 16'h1020;
    localparam logic [15:0] PORTREG_HI = 16'h102F;

    // Register index inside one port's group of four, address bits [1:0].
    localparam logic [1:0] REG_SEL1 = 2'h0;
    localparam logic [1:0] REG_SEL2 = 2'h1;
    localparam logic [1:0] REG_DATA = 2'h2;
    localparam logic [1:0] REG_DIR = 2'h3;

    // Phases of the quarter-rate clock; the output clock is high in the last two.
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_STROBE = 2'h1;
    localparam logic [1:0] PH_RISE = 2'h2;
    localparam logic [1:0] PH_END = 2'h3;

    // Function select values loaded after reset in each startup mode.
    localparam logic [7:0] SEL_RESET_MC = 8'h00;
    localparam logic [7:0] SEL_RESET_MP = 8'hFF;

    // Port roles.
    localparam int PORT_DATA = 0;
    localparam int PORT_LADDR = 1;
    localparam int PORT_HADDR = 2;
    localparam int PORT_CTRL = 3;

    // Control port bit positions, first alternate function.
    localparam int PD_EIGHTH_REGION_SELECT_2 = 0;
    localparam int PD_UPPER_HALF_SELECT_3 = 1;
    localparam int PD_UPPER_HALF_SELECT_2 = 2;
    localparam int PD_CLK = 3;
    localparam int PD_RW = 4;
    localparam int PD_PERIPH_FRAME_SELECT = 5;
    localparam int PD_UPPER_HALF_SELECT_1 = 6;
    localparam int PD_EIGHTH_REGION_SELECT_1 = 7;
    // Control port bit positions, second alternate function.
    localparam int PD_OCF = 0;
    localparam int PD_EDS = 6;
    localparam int PD_WAIT = 7;

    // One bus request from the core.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic write;
        logic fetch;
    } xb_req_t;

    // The four control registers of one port.
    typedef struct packed {
        logic [7:0] sel1;
        logic [7:0] sel2;
        logic [7:0] data;
        logic [7:0] dir;
    } xb_port_t;

    // Bus engine states.
    typedef enum logic [1:0] {
        XB_IDLE,
        XB_ACT
    } xb_state_t;

endpackage
`default_nettype wire

// *** tb/xb_expansion_bus_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Self-checking bench of the expansion bus.
// =====================================================================
module xb_expansion_bus_tb
    import xb_pkg::*;
;
    logic mclk, arst_n, mode_strap, req_valid, wait_n, req_ready, rsp_valid, mode_mp;
    xb_req_t req;
    logic [7:0] rsp_data, snap_d, snap_a0, snap_oe0, clk_s;
    logic [15:0] snap_addr;
    logic [XB_NPORT-1:0][7:0] pin_in, pin_out, pin_oe, ext;
    logic prev_s, saw_full;
    int mismatches, check_count, cycles, low_cnt, n_strobe, n0;
    logic [24:0] rows [11]; // Address, write, expected select bits.

    // A pin driven by the device shows its drive, else the far side.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);

    xb_expansion_bus i_xb_expansion_bus (.mclk(mclk), .arst_n(arst_n),
        .mode_strap(mode_strap), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mode_mp(mode_mp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe));
    xb_mem_model i_xb_mem_model (.mclk(mclk), .wait_n(wait_n), .pin_out(pin_out), .ext(ext));

    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Counts strobes, notes a full FIFO and cuts a hang short.
    always @(negedge mclk)
    begin
        if (prev_s && !pin_out[3][6]) n_strobe++;
        prev_s = pin_out[3][6];
        if (!req_ready) saw_full = 1'b1;
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run;
        end
    end

    task chk(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Offers one request and holds it until the FIFO takes it.
    task go(input logic [15:0] a, input logic [7:0] wd, input logic wr, input logic fe);
        @(posedge mclk);
        req_valid <= 1'b1;
        req <= {a, wd, wr, fe};
        do @(negedge mclk); while (req_ready !== 1'b1);
        @(posedge mclk);
        req_valid <= 1'b0;
    endtask

    // Runs one external cycle, snapshots the pins and measures the strobe.
    task bus(input logic [15:0] a, input logic [7:0] wd, input logic wr, input logic fe);
        go(a, wd, wr, fe);
        do @(negedge mclk); while (pin_out[3][6] !== 1'b0);
        snap_d = pin_out[3];
        snap_addr = {pin_out[2], pin_out[1]};
        snap_a0 = pin_out[0];
        snap_oe0 = pin_oe[0];
        low_cnt = 1;
        @(posedge mclk) wait_n <= 1'b1;
        @(negedge mclk);
        while (pin_out[3][6] === 1'b0)
        begin
            low_cnt++;
            @(negedge mclk);
        end
        chk({snap_addr, snap_d[4]}, {a, ~wr});
        if (wr)
            chk({snap_oe0, snap_a0}, {8'hFF, wd});
        else
            chk({rsp_valid, rsp_data, snap_oe0}, {1'b1, a[7:0] ^ 8'hA5, 8'h00});
    endtask

    initial
    begin
        arst_n = 1'b0;
        mode_strap = 1'b1;
        req_valid = 1'b0;
        req = '0;
        wait_n = 1'b1;
        rows = '{{16'h1FFF, 1'b0, 8'hA7}, {16'h2000, 1'b1, 8'h26}, {16'h3FFF, 1'b0, 8'h26},
            {16'h4000, 1'b1, 8'hA7}, {16'h7FFF, 1'b0, 8'hA7}, {16'h8000, 1'b1, 8'hA1},
            {16'hFFFF, 1'b0, 8'hA1}, {16'h10BF, 1'b0, 8'hA7}, {16'h10C0, 1'b1, 8'h87},
            {16'h10FF, 1'b0, 8'h87}, {16'h1100, 1'b0, 8'hA7}};
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk({mode_mp, pin_oe[1], pin_oe[2], pin_out[3][6]}, {1'b1, 16'hFFFF, 1'b1});
        for (int i = 0; i < 8; i++)
        begin
            @(negedge mclk);
            clk_s[i] = pin_out[3][3];
        end
        chk({clk_s[3:0] ^ clk_s[7:4], clk_s[1:0] ^ clk_s[3:2]}, 6'h03);
        bus(16'h8001, 8'h00, 1'b0, 1'b1);
        chk({snap_d[0], pin_out[3][0], low_cnt[3:0]}, {2'b01, 4'd3});
        bus(16'h8002, 8'h00, 1'b0, 1'b0);
        chk(snap_d[0], 1'b1);
        @(posedge mclk) wait_n <= 1'b0;
        bus(16'h9000, 8'h00, 1'b0, 1'b0);
        chk(low_cnt, 7);
        $display("startup, fetch and wait tests done");
        bus(16'h102C, 8'h40, 1'b1, 1'b0);
        foreach (rows[i])
        begin
            bus(rows[i][24:9], rows[i][16:9], rows[i][8], 1'b0);
            chk({snap_d & 8'hA7, pin_out[3] & 8'hA7}, {rows[i][7:0], 8'hA7});
        end
        bus(16'h102E, 8'h04, 1'b1, 1'b0);
        bus(16'h102F, 8'h04, 1'b1, 1'b0);
        bus(16'h102D, 8'hFB, 1'b1, 1'b0);
        bus(16'hC000, 8'h00, 1'b0, 1'b0);
        chk({snap_d[2:1], pin_oe[3][2]}, 3'b101);
        $display("select tests done");
        saw_full = 1'b0;
        n0 = n_strobe;
        repeat (24) go(16'h4000, 8'hA5, 1'b1, 1'b0);
        while (n_strobe - n0 < 24) @(negedge mclk);
        chk({saw_full, req_ready, n_strobe - n0}, {2'b11, 32'd24});
        $display("fifo test done");
        @(posedge mclk);
        arst_n <= 1'b0;
        mode_strap <= 1'b0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk({mode_mp, pin_oe}, 33'h0);
        go(16'h1022, 8'h5A, 1'b1, 1'b0);
        go(16'h1023, 8'h0F, 1'b1, 1'b0);
        go(16'h1022, 8'h00, 1'b0, 1'b0);
        do @(negedge mclk); while (rsp_valid !== 1'b1);
        chk({pin_oe[0], pin_out[0][3:0], rsp_data[3:0], pin_oe[1]}, {8'h0F, 8'hAA, 8'h00});
        $display("single-chip test done");
        complete_run;
    end
endmodule
`default_nettype wire

// *** tb/xb_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Far side: memory banks and peripherals on the expansion bus.
// =====================================================================
module xb_mem_model
    import xb_pkg::*;
(
    input wire logic mclk,                          // Clock.
    input wire logic wait_n,                        // Low asks for wait states.
    input wire logic [XB_NPORT-1:0][7:0] pin_out,   // Device drive values.
    output logic [XB_NPORT-1:0][7:0] ext            // Far side levels.
);
    logic [7:0] junk; // Filler on a released data bus.

    // The filler flips every cycle so stale data never looks valid.
    always @(posedge mclk)
    begin
        junk <= (junk === 8'h55) ? 8'hAA : 8'h55;
    end

    // Memory answers a read while the strobe is low, else the data lines show the filler; wait follows wait_n, other lines pull up.
    always_comb
    begin
        ext = '1;
        ext[PORT_CTRL][PD_WAIT] = wait_n;
        ext[PORT_DATA] = junk;
        if (!pin_out[PORT_CTRL][PD_EDS] && pin_out[PORT_CTRL][PD_RW])
            ext[PORT_DATA] = pin_out[PORT_LADDR] ^ 8'hA5;
    end
endmodule
`default_nettype wire
